/* rtl/pbg_map.vh */
`ifndef PBG_MAP_VH
`define PBG_MAP_VH

// Register indexes; the APB byte address is four times the index
`define PBG_IDX_PORT_DATA     8'h06
`define PBG_IDX_OPTION_CONFIG 8'h81
`define PBG_IDX_PIN_DIRECTION 8'h86
`define PBG_IDX_PULLUP_ENABLE 8'h95
`define PBG_IDX_CHANGE_INT_EN 8'h96
`define PBG_IDX_ANALOG_SELECT 8'h9d
`define PBG_IDX_INT_CONTROL   8'ha0
`define PBG_IDX_TIMER1_OSC    8'ha1

// Reset values
`define PBG_RST_PORT_DATA     8'h00
`define PBG_RST_OPTION_CONFIG 8'hff
`define PBG_RST_PIN_DIRECTION 8'hff
`define PBG_RST_PULLUP_ENABLE 8'hff
`define PBG_RST_CHANGE_INT_EN 8'hf0
`define PBG_RST_ANALOG_SELECT 6'h3f
`define PBG_RST_INT_CONTROL   8'h00
`define PBG_RST_TIMER1_OSC    1'b0
`define PBG_RST_CHANGE_GL_EN  1'b0
`define PBG_RST_GLOBAL_INT_EN 1'b0

// Field positions
`define PBG_OPT_PULLUP_GLOBAL_OFF 7
`define PBG_INTC_CHANGE_FLAG      0
`define PBG_INTC_CHANGE_GLOBAL_EN 3
`define PBG_INTC_GLOBAL_INT_EN    7
`define PBG_ANS_PORT_BIT0         4
`define PBG_ANS_PORT_BIT1         5
`define PBG_ANS_WIDTH             6
`define PBG_T1OSC_EN              0
`define PBG_PIN_T1OSC             7

`endif

/* rtl/pbg_port.v */
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "pbg_map.vh"

module pbg_port (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// Port pins
	input  wire [7:0]  pin_in,
	output reg  [7:0]  pin_out,
	output reg  [7:0]  pin_oe,
	output reg  [7:0]  pullup_on,
	// Shared pin functions
	input  wire        pwm_out_d_en,
	input  wire        pwm_out_d_val,
	output reg         analog_in4_mode,
	output reg         analog_in5_mode,
	output reg         timer1_osc_owns_pin7,
	// Core events
	output reg         change_int_req,
	output reg         wake_req
);

	reg  [7:0]  port_data_q;
	reg  [7:0]  option_config_q;
	reg  [7:0]  pin_direction_q;
	reg  [7:0]  pullup_enable_q;
	reg  [7:0]  change_int_enable_q;
	reg  [5:0]  analog_select_q;
	reg         change_int_flag_q;
	reg         change_int_global_enable_q;
	reg         global_int_enable_q;
	reg         timer1_osc_enable_q;
	reg  [7:0]  compare_q;
	reg  [7:0]  port_read_val;
	reg  [7:0]  port_data_d;
	reg  [7:0]  mismatch_bits;
	reg         mismatch;
	reg         change_int_flag_d;
	reg  [31:0] rd_mux;
	reg         addr_hit;
	wire [7:0]  idx;
	wire        setup_ph;
	wire        access_ph;
	wire        wr_en;
	wire        wr_lane0;
	wire        port_touch;

	// Zero-wait slave; index is the word address
	assign idx       = paddr[9:2];
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign pready    = 1'b1;
	assign wr_en     = access_ph & pwrite & addr_hit;
	assign wr_lane0  = wr_en & pstrb[0];
	assign pslverr   = access_ph & ~addr_hit;
	assign port_touch = access_ph & (idx == `PBG_IDX_PORT_DATA) & addr_hit;

	// Address decode; upper and low address bits must be clear
	always @* begin
		addr_hit = 1'b0;
		if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
			case (idx)
				`PBG_IDX_PORT_DATA,
				`PBG_IDX_OPTION_CONFIG,
				`PBG_IDX_PIN_DIRECTION,
				`PBG_IDX_PULLUP_ENABLE,
				`PBG_IDX_CHANGE_INT_EN,
				`PBG_IDX_ANALOG_SELECT,
				`PBG_IDX_INT_CONTROL,
				`PBG_IDX_TIMER1_OSC: addr_hit = 1'b1;
				default: addr_hit = 1'b0;
			endcase
		end
	end

	// Pin level as software sees it; analog pins read as one
	always @* begin
		port_read_val = pin_in;
		if (analog_select_q[`PBG_ANS_PORT_BIT0])
			port_read_val[0] = 1'b1;
		if (analog_select_q[`PBG_ANS_PORT_BIT1])
			port_read_val[1] = 1'b1;
	end

	// Read-modify-write: unstrobed low lane keeps the sampled pin levels
	always @* begin
		port_data_d = port_data_q;
		if (wr_en && idx == `PBG_IDX_PORT_DATA)
			port_data_d = pstrb[0] ? pwdata[7:0] : port_read_val;
	end

	// Change detect: input pins only, each gated by its own enable
	always @* begin
		mismatch_bits = (port_read_val ^ compare_q) & change_int_enable_q & pin_direction_q;
		mismatch      = |mismatch_bits;
	end

	// Flag set wins over a software clear in the same cycle
	always @* begin
		change_int_flag_d = change_int_flag_q;
		if (wr_lane0 && idx == `PBG_IDX_INT_CONTROL)
			change_int_flag_d = pwdata[`PBG_INTC_CHANGE_FLAG];
		if (mismatch)
			change_int_flag_d = 1'b1;
	end

	// Read data captured in setup so it is stable through access
	always @* begin
		rd_mux = 32'h0000_0000;
		case (idx)
			`PBG_IDX_PORT_DATA:     rd_mux[7:0] = port_read_val;
			`PBG_IDX_OPTION_CONFIG: rd_mux[7:0] = option_config_q;
			`PBG_IDX_PIN_DIRECTION: rd_mux[7:0] = pin_direction_q;
			`PBG_IDX_PULLUP_ENABLE: rd_mux[7:0] = pullup_enable_q;
			`PBG_IDX_CHANGE_INT_EN: rd_mux[7:0] = change_int_enable_q;
			`PBG_IDX_ANALOG_SELECT: rd_mux[5:0] = analog_select_q;
			`PBG_IDX_INT_CONTROL: begin
				rd_mux[`PBG_INTC_CHANGE_FLAG]      = change_int_flag_q;
				rd_mux[`PBG_INTC_CHANGE_GLOBAL_EN] = change_int_global_enable_q;
				rd_mux[`PBG_INTC_GLOBAL_INT_EN]    = global_int_enable_q;
			end
			`PBG_IDX_TIMER1_OSC:    rd_mux[`PBG_T1OSC_EN] = timer1_osc_enable_q;
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
			prdata <= addr_hit ? rd_mux : 32'h0000_0000;
	end

	// Software registers; reset puts pull-ups off and pins 1,0 analog
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_q         <= `PBG_RST_PORT_DATA;
			option_config_q     <= `PBG_RST_OPTION_CONFIG;
			pin_direction_q     <= `PBG_RST_PIN_DIRECTION;
			pullup_enable_q     <= `PBG_RST_PULLUP_ENABLE;
			change_int_enable_q <= `PBG_RST_CHANGE_INT_EN;
			analog_select_q     <= `PBG_RST_ANALOG_SELECT;
			change_int_global_enable_q <= `PBG_RST_CHANGE_GL_EN;
			global_int_enable_q <= `PBG_RST_GLOBAL_INT_EN;
			timer1_osc_enable_q <= `PBG_RST_TIMER1_OSC;
		end else begin
			port_data_q <= port_data_d;
			if (wr_lane0) begin
				case (idx)
					`PBG_IDX_OPTION_CONFIG: option_config_q     <= pwdata[7:0];
					`PBG_IDX_PIN_DIRECTION: pin_direction_q     <= pwdata[7:0];
					`PBG_IDX_PULLUP_ENABLE: pullup_enable_q     <= pwdata[7:0];
					`PBG_IDX_CHANGE_INT_EN: change_int_enable_q <= pwdata[7:0];
					`PBG_IDX_ANALOG_SELECT: analog_select_q     <= pwdata[5:0];
					`PBG_IDX_INT_CONTROL: begin
						change_int_global_enable_q <= pwdata[`PBG_INTC_CHANGE_GLOBAL_EN];
						global_int_enable_q        <= pwdata[`PBG_INTC_GLOBAL_INT_EN];
					end
					`PBG_IDX_TIMER1_OSC: timer1_osc_enable_q <= pwdata[`PBG_T1OSC_EN];
					default: timer1_osc_enable_q <= timer1_osc_enable_q;
				endcase
			end
		end
	end

	// Compare latch follows every port access; a change in that same cycle still sets the flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_q         <= 8'h00;
			change_int_flag_q <= 1'b0;
		end else begin
			if (port_touch)
				compare_q <= port_read_val;
			change_int_flag_q <= change_int_flag_d;
		end
	end

	// Pin drivers, pull-ups and shared functions, all from flip-flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out              <= 8'h00;
			pin_oe               <= 8'h00;
			pullup_on            <= 8'h00;
			analog_in4_mode      <= 1'b1;
			analog_in5_mode      <= 1'b1;
			timer1_osc_owns_pin7 <= 1'b0;
			change_int_req       <= 1'b0;
			wake_req             <= 1'b0;
		end else begin
			pin_out <= port_data_q;
			pin_oe  <= ~pin_direction_q;
			// Pull-up needs enable, global on, and input direction
			pullup_on <= pullup_enable_q & pin_direction_q &
				{8{~option_config_q[`PBG_OPT_PULLUP_GLOBAL_OFF]}};
			if (pwm_out_d_en) begin
				pin_out[`PBG_PIN_T1OSC] <= pwm_out_d_val;
				pin_oe[`PBG_PIN_T1OSC]  <= 1'b1;
			end
			// Oscillator wins over port latch and PWM alike
			if (timer1_osc_enable_q) begin
				pin_out[`PBG_PIN_T1OSC]    <= 1'b0;
				pin_oe[`PBG_PIN_T1OSC]     <= 1'b0;
				pullup_on[`PBG_PIN_T1OSC]  <= 1'b0;
			end
			timer1_osc_owns_pin7 <= timer1_osc_enable_q;
			analog_in4_mode <= analog_select_q[`PBG_ANS_PORT_BIT0];
			analog_in5_mode <= analog_select_q[`PBG_ANS_PORT_BIT1];
			// Wake ignores the global enable; sleep exit needs only the source
			wake_req <= change_int_flag_q & change_int_global_enable_q;
			change_int_req <= change_int_flag_q & change_int_global_enable_q &
				global_int_enable_q;
		end
	end

endmodule

/* bench/pbg_pins_model.sv */
`timescale 1ns/100ps
module pbg_pins_model (
	// Clock for the floating pattern
	input  wire       pclk,
	// Device side of the pins
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	input  wire [7:0] pullup_on,
	// Board side, set by the bench
	input  wire [7:0] ext_drv,
	input  wire [7:0] ext_val,
	output wire [7:0] pin_in
);
	reg [7:0] float_q = 8'h55;
	// Undriven pins wander so a stale level never reads back
	always @(posedge pclk) begin
		float_q <= ~float_q;
	end
	// Device driver first, then board, then weak pull-up
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) | (~pin_oe & ~ext_drv & (pullup_on | float_q));
endmodule

/* bench/pbg_port_properties.sv */
`timescale 1ns/100ps
module pbg_port_properties (
	// Clock, reset and APB
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	// Pins and events
	input logic [7:0]  pin_oe,
	input logic [7:0]  pullup_on,
	input logic        timer1_osc_owns_pin7,
	input logic        change_int_req,
	input logic        wake_req
);
	// Writes land on the access edge
	wire wr    = psel && penable && pwrite;
	wire wr_ic = wr && paddr == 12'h280;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_oe; wr && paddr == 12'h218 |=> ##1 pin_oe[6:0] == ~$past(pwdata[6:0], 2); endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_pu_dir; wr && paddr == 12'h218 |=> ##1 (pullup_on & ~$past(pwdata[7:0], 2)) == 8'h00; endproperty
	a_pu_dir: assert property (p_pu_dir) else $error("pull dir");
	property p_pu_off; (pullup_on & pin_oe) == 8'h00; endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull out");
	property p_pu_rst; !$past(presetn) |-> pullup_on == 8'h00; endproperty
	a_pu_rst: assert property (p_pu_rst) else $error("pull rst");
	property p_osc; wr && paddr == 12'h284 |=> ##1 timer1_osc_owns_pin7 == $past(pwdata[0], 2); endproperty
	a_osc: assert property (p_osc) else $error("osc");
	property p_gie; change_int_req |-> wake_req; endproperty
	a_gie: assert property (p_gie) else $error("irq");
	property p_hold; wake_req && !wr_ic && !$past(wr_ic) |=> wake_req; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_ic; wr_ic && !pwdata[3] |=> ##1 !wake_req && !change_int_req; endproperty
	a_ic: assert property (p_ic) else $error("en");
endmodule
bind pbg_port pbg_port_properties pbg_port_properties_i (.*);

/* bench/pbg_port_tb_top.sv */
`timescale 1ns/100ps
module pbg_port_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
	logic        pwm_out_d_en = 0, pwm_out_d_val = 0, analog_in4_mode, analog_in5_mode;
	logic        timer1_osc_owns_pin7, change_int_req, wake_req;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0]  pstrb = 4'hf;
	logic [7:0]  pin_in, pin_out, pin_oe, pullup_on, r, ext_drv = 8'h00, ext_val = 8'h00;
	int          fails = 0, checks = 0;
	pbg_port       pbg_port_i (.*);
	pbg_pins_model pbg_pins_model_i (.*);
	// 25 MHz clock
	always #20 pclk = ~pclk;
	task final_report;
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One transfer held until pready, then n idle edges
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input int n);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			fails++;
			final_report;
		end
		r = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	// Reset state, drivers and pull-up gating
	task t_pins;
		chk(pullup_on, 8'h00);
		chk({analog_in5_mode, analog_in4_mode, pin_oe[5:0]}, 8'hc0);
		apb(0, 12'h258, 8'h00, 0);
		chk(r, 8'hf0);
		apb(0, 12'h018, 8'h00, 0);
		chk(r & 8'h03, 8'h03);
		apb(1, 12'h018, 8'ha5, 0);
		apb(1, 12'h218, 8'h00, 2);
		chk(pin_out, 8'ha5);
		chk(pin_oe & ~pullup_on, 8'hff);
		apb(1, 12'h204, 8'h7f, 0);
		apb(1, 12'h218, 8'hf3, 2);
		chk(pullup_on, 8'hf3);
		apb(1, 12'h254, 8'h3f, 2);
		chk(pullup_on, 8'h33);
		apb(1, 12'h204, 8'hff, 0);
		apb(1, 12'h218, 8'hff, 2);
		chk(pin_oe | pullup_on, 8'h00);
	endtask
	// Change flag, its clearing and both enables
	task t_chg;
		ext_drv <= 8'hff;
		apb(1, 12'h274, 8'h00, 2);
		chk({6'h00, analog_in5_mode, analog_in4_mode}, 8'h00);
		apb(1, 12'h280, 8'h88, 0);
		apb(0, 12'h018, 8'h00, 0);
		chk(r, 8'h00);
		apb(1, 12'h280, 8'h88, 2);
		ext_val <= 8'h04;
		apb(1, 12'h258, 8'h08, 4);
		chk({6'h00, change_int_req, wake_req}, 8'h00);
		ext_val <= 8'h0c;
		apb(1, 12'h258, 8'h08, 4);
		chk({6'h00, change_int_req, wake_req}, 8'h03);
		apb(1, 12'h280, 8'h88, 0);
		apb(0, 12'h280, 8'h00, 0);
		chk(r, 8'h89);
		apb(0, 12'h018, 8'h00, 0);
		apb(1, 12'h280, 8'h88, 0);
		apb(0, 12'h280, 8'h00, 3);
		chk(r, 8'h88);
		ext_val <= 8'h04;
		apb(1, 12'h280, 8'h09, 4);
		chk({6'h00, change_int_req, wake_req}, 8'h01);
		apb(1, 12'h280, 8'h01, 3);
		chk({7'h00, wake_req}, 8'h00);
	endtask
	// Oscillator takeover and an unmapped access
	task t_misc;
		apb(1, 12'h284, 8'h01, 2);
		chk({7'h00, timer1_osc_owns_pin7}, 8'h01);
		apb(1, 12'h2fc, 8'h00, 0);
		chk({7'h00, err}, 8'h01);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_pins;
		t_chg;
		t_misc;
		final_report;
	end
endmodule
